// File: include/swtc_regs.svh
// constants for the sleep and wake timing controller
// Functional notes
// - option word accepts 0..0x13e; refuse both coordinator bits set together.
// - sync option bits 0..5: force, forbid coordinator, status, early wake, equality, deploy.
// - async option bit 8 keeps the device awake full wake time every Nth wake.
// - async mode asserts host indicator every Nth wake; N 1..0xffff, default 1.
// - other wakes briefly check for data; data wakes fully, else sleep again.
// - cycle count N has no effect in synchronous sleep.
// - sleep time in 10 ms units, range 0x1..0x15f900, default 0x12c.
// - async: stay awake wake time in 1 ms units after data, default 0xd08.
// - sync: wake time raised to computed minimum, capped at 0x36ee80 ms.
// - nonzero host wake delay holds serial output that many ms after waking.
// - a serial character from host stops the host wake delay at once, except one arriving in the cycle the delay loads.
// - sync: sleep shortened by host delay; awake at least delay plus one hop.
// - status bits 0..3: awake, coordinator, ever synced, synced this cycle.
// - status bit 4 pending settings, bit 5 nomination, bit 6 deployment.
// - operating sleep readout gives network sleep, else configured, 10 ms units.
// - operating wake readout gives network wake, else configured, 1 ms units.
// - readable count of sleep or wake cycles since last sync.
// - missed sync counter counts sleeps without sync, saturates 0xffff, write 0 clears.
// - sleep mode 4 selects asynchronous cyclic sleep.
// - sleep mode 8 selects synchronized cyclic sleep.
`ifndef SWTC_REGS_SVH
`define SWTC_REGS_SVH
// ==========================================
// parameter selectors
`define SWTC_SEL_OPT  4'h0
`define SWTC_SEL_CNT  4'h1
`define SWTC_SEL_SP   4'h2
`define SWTC_SEL_ST   4'h3
`define SWTC_SEL_WH   4'h4
`define SWTC_SEL_STAT 4'h5
`define SWTC_SEL_OS   4'h6
`define SWTC_SEL_OW   4'h7
`define SWTC_SEL_MS   4'h8
`define SWTC_SEL_SQ   4'h9
`define SWTC_SEL_SM   4'ha
// ==========================================
// reset values and limits
`define SWTC_OPT_RST  16'h0002
`define SWTC_CNT_RST  16'h0001
`define SWTC_SP_RST   24'h00012c
`define SWTC_ST_RST   24'h000d08
`define SWTC_OPT_MAX  24'h00013e
`define SWTC_SP_MAX   24'h15f900
`define SWTC_ST_MAX   24'h36ee80
`define SWTC_MODE_ASYNC 4'h4
`define SWTC_MODE_SYNC  4'h8
// ==========================================
// option bit positions
`define SWTC_OPT_PREF     0
`define SWTC_OPT_NOCOORD  1
`define SWTC_OPT_NODEPLOY 5
`define SWTC_OPT_FULLWAKE 8
// ==========================================
// timing
`define SWTC_CLK_NS   10
`define SWTC_MS_NS    1000000
`define SWTC_SP_UNIT_MS 28'h000000a
`define SWTC_CHECK_MS 24'h000005
`endif

// File: include/swtc_pkg.sv
// types of the sleep and wake timing controller
package swtc_pkg;
  typedef enum logic [1:0] {
    SWTC_IDLE  = 2'h0,
    SWTC_SLEEP = 2'h1,
    SWTC_CHECK = 2'h3,
    SWTC_WAKE  = 2'h2
  } swtc_state_t;
endpackage

// File: hw/swtc_tick_div.sv
// millisecond enable divider
`timescale 1ns/100ps
`default_nettype none
module swtc_tick_div #(
  parameter int CYC = 100000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick_q
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_d;

  always_comb
  begin
    tick_d = (cnt_q == 32'(CYC - 1));
    cnt_d  = tick_d ? 32'h0 : cnt_q + 32'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  property p_tick_one;
    @(posedge clk) disable iff (sys_rst) tick_q |=> !tick_q || (CYC == 1);
  endproperty
  a_tick_one : assert property (p_tick_one) else $error("tick longer than one cycle");
endmodule
`default_nettype wire

// File: hw/swtc_ms_timer.sv
// millisecond down timer with load and stop
`timescale 1ns/100ps
`default_nettype none
module swtc_ms_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         stop,
  output logic              busy,
  output logic              done_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load)
      cnt_d = load_val;
    else if (stop)
      cnt_d = '0;
    else if (tick && cnt_q != '0)
    begin
      cnt_d  = cnt_q - W'(1);
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);

  property p_done_end;
    @(posedge clk) disable iff (sys_rst) done_q |-> $past(cnt_q) == W'(1) && !$past(load);
  endproperty
  a_done_end : assert property (p_done_end) else $error("timer done without expiry");
endmodule
`default_nettype wire

// File: hw/swtc_core.sv
// sleep and wake timing controller core
`timescale 1ns/100ps
`default_nettype none
`include "swtc_regs.svh"
module swtc_core #(
  parameter int          MS_CYCLES = `SWTC_MS_NS / `SWTC_CLK_NS,
  parameter logic [23:0] HOP_MS    = 24'h000032,
  parameter logic [23:0] CHECK_MS  = `SWTC_CHECK_MS
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_sel,
  input  wire logic [23:0] cmd_wdata,
  input  wire logic        uart_rx_char,
  input  wire logic        rf_rx_pkt,
  input  wire logic        sync_rx,
  input  wire logic [23:0] sync_sp,
  input  wire logic [23:0] sync_st,
  input  wire logic        nominate_req,
  output logic             rsp_valid_q,
  output logic [23:0]      rsp_data_q,
  output logic             rsp_err_q,
  output logic             host_ind_q,
  output logic             host_hold,
  output logic             sync_tx_q,
  output logic             coord
);
  // ==========================================
  // declarations
  logic [15:0] opt_q, opt_d, cnt_q, cnt_d, wh_q, wh_d, sq_q, sq_d;
  logic [23:0] sp_q, sp_d, st_q, st_d, rd_d;
  logic [3:0]  sm_q, sm_d;
  logic        pend_q, pend_d, nom_q, nom_d, err_d, ok;
  swtc_pkg::swtc_state_t s_q, s_d;
  logic [15:0] wcnt_q, wcnt_d, mss_q, mss_d;
  logic [23:0] nsp_q, nsp_d, nst_q, nst_d, ld_val;
  logic        syn_q, syn_d, ever_q, ever_d, cyc_q, cyc_d, ind_d, tx_d;
  logic        ld, sq_inc, wake_start, ms_tick, tmr_done, wh_busy, wh_done;
  logic        async_m, sync_m, data_seen, deploy, wr;
  logic [23:0] op_sp, op_st, wh24, min_wake, eff_wake, sp_ms, sleep_val, entry_val;
  logic [27:0] sp_prod;

  assign wr        = cmd_valid && cmd_write;
  assign async_m   = (sm_q == `SWTC_MODE_ASYNC);
  assign sync_m    = (sm_q == `SWTC_MODE_SYNC);
  assign data_seen = uart_rx_char || rf_rx_pkt;
  assign wh24      = {8'h00, wh_q};

  // ==========================================
  // derived timing
  // unsynchronized nodes fall back to configured times
  assign op_sp = syn_q ? nsp_q : sp_q;
  assign op_st = syn_q ? nst_q : st_q;
  assign sp_prod = {4'h0, op_sp} * `SWTC_SP_UNIT_MS;
  assign sp_ms   = sp_prod[23:0];
  assign min_wake = wh24 + HOP_MS;
  always_comb
  begin
    eff_wake = (op_st < min_wake) ? min_wake : op_st;
    if (eff_wake > `SWTC_ST_MAX)
      eff_wake = `SWTC_ST_MAX;
    // sleep shortened so the host is ready when the network wakes
    sleep_val = sp_ms;
    if (sync_m)
      sleep_val = (sp_ms > wh24) ? sp_ms - wh24 : 24'h000001;
    entry_val = opt_q[`SWTC_OPT_FULLWAKE] ? st_q : CHECK_MS;
  end
  assign coord = sync_m && (opt_q[`SWTC_OPT_PREF] ||
                 (!opt_q[`SWTC_OPT_NOCOORD] && (!syn_q || nom_q)));
  assign deploy = sync_m && !syn_q && !opt_q[`SWTC_OPT_NODEPLOY];

  // ==========================================
  // parameter port
  always_comb
  begin
    opt_d  = opt_q;
    cnt_d  = cnt_q;
    sp_d   = sp_q;
    st_d   = st_q;
    wh_d   = wh_q;
    sm_d   = sm_q;
    sq_d   = sq_q;
    pend_d = pend_q;
    nom_d  = nom_q;
    ok     = 1'b1;
    rd_d   = 24'h000000;
    case (cmd_sel)
      `SWTC_SEL_OPT:  rd_d = {8'h00, opt_q};
      `SWTC_SEL_CNT:  rd_d = {8'h00, cnt_q};
      `SWTC_SEL_SP:   rd_d = sp_q;
      `SWTC_SEL_ST:   rd_d = st_q;
      `SWTC_SEL_WH:   rd_d = wh24;
      `SWTC_SEL_STAT: rd_d = {17'h00000, deploy, nom_q, pend_q, cyc_q, ever_q, coord,
                              host_ind_q && sync_m};
      `SWTC_SEL_OS:   rd_d = op_sp;
      `SWTC_SEL_OW:   rd_d = op_st;
      `SWTC_SEL_MS:   rd_d = {8'h00, mss_q};
      `SWTC_SEL_SQ:   rd_d = {8'h00, sq_q};
      `SWTC_SEL_SM:   rd_d = {20'h00000, sm_q};
      default:        ok = !cmd_write;
    endcase
    if (wr)
    begin
      case (cmd_sel)
        `SWTC_SEL_OPT:
          ok = (cmd_wdata <= `SWTC_OPT_MAX) && !(cmd_wdata[0] && cmd_wdata[1]);
        `SWTC_SEL_CNT:
          ok = (cmd_wdata[23:16] == 8'h00) && (cmd_wdata != 24'h000000);
        `SWTC_SEL_SP:
          ok = (cmd_wdata != 24'h000000) && (cmd_wdata <= `SWTC_SP_MAX);
        `SWTC_SEL_ST:
          ok = (cmd_wdata != 24'h000000) && (cmd_wdata <= `SWTC_ST_MAX);
        `SWTC_SEL_WH:
          ok = (cmd_wdata[23:16] == 8'h00);
        `SWTC_SEL_SQ:
          ok = (cmd_wdata == 24'h000000);
        `SWTC_SEL_SM:
          ok = (cmd_wdata <= 24'h000008) && (cmd_wdata[3:0] != 4'h2) &&
               (cmd_wdata[3:0] != 4'h3) && (cmd_wdata[3:0] != 4'h6);
        default:
          ok = 1'b0;
      endcase
      if (ok)
      begin
        case (cmd_sel)
          `SWTC_SEL_OPT: opt_d = cmd_wdata[15:0];
          `SWTC_SEL_CNT: cnt_d = cmd_wdata[15:0];
          `SWTC_SEL_SP:  sp_d  = cmd_wdata;
          `SWTC_SEL_ST:  st_d  = cmd_wdata;
          `SWTC_SEL_WH:  wh_d  = cmd_wdata[15:0];
          `SWTC_SEL_SQ:  sq_d  = 16'h0000;
          `SWTC_SEL_SM:  sm_d  = cmd_wdata[3:0];
          default:       sm_d  = sm_q;
        endcase
        // a coordinator announces new settings at the next wake
        if (sync_m && coord && (cmd_sel == `SWTC_SEL_OPT || cmd_sel == `SWTC_SEL_SP ||
            cmd_sel == `SWTC_SEL_ST))
          pend_d = 1'b1;
      end
    end
    // hardware events win over clears in the same cycle
    if (wake_start)
    begin
      pend_d = 1'b0;
      nom_d  = 1'b0;
    end
    if (nominate_req && sync_m)
      nom_d = 1'b1;
    if (sq_inc && sq_d != 16'hffff)
      sq_d = sq_d + 16'h0001;
    err_d = cmd_valid && !ok;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opt_q       <= `SWTC_OPT_RST;
      cnt_q       <= `SWTC_CNT_RST;
      sp_q        <= `SWTC_SP_RST;
      st_q        <= `SWTC_ST_RST;
      wh_q        <= 16'h0000;
      sm_q        <= 4'h0;
      sq_q        <= 16'h0000;
      pend_q      <= 1'b0;
      nom_q       <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_data_q  <= 24'h000000;
    end
    else
    begin
      opt_q       <= opt_d;
      cnt_q       <= cnt_d;
      sp_q        <= sp_d;
      st_q        <= st_d;
      wh_q        <= wh_d;
      sm_q        <= sm_d;
      sq_q        <= sq_d;
      pend_q      <= pend_d;
      nom_q       <= nom_d;
      rsp_valid_q <= cmd_valid;
      rsp_err_q   <= err_d;
      rsp_data_q  <= rd_d;
    end
  end

  // ==========================================
  // sleep sequencer
  always_comb
  begin
    s_d        = s_q;
    wcnt_d     = wcnt_q;
    mss_d      = mss_q;
    nsp_d      = nsp_q;
    nst_d      = nst_q;
    syn_d      = syn_q;
    ever_d     = ever_q;
    cyc_d      = cyc_q;
    ind_d      = host_ind_q;
    tx_d       = 1'b0;
    ld         = 1'b0;
    ld_val     = st_q;
    sq_inc     = 1'b0;
    wake_start = 1'b0;
    case (s_q)
      swtc_pkg::SWTC_IDLE:
        if (async_m || sync_m)
        begin
          s_d    = swtc_pkg::SWTC_WAKE;
          ld     = 1'b1;
          ld_val = sync_m ? eff_wake : st_q;
        end
      swtc_pkg::SWTC_WAKE:
        if (async_m && data_seen)
        begin
          ld     = 1'b1;
          ld_val = st_q;
        end
        else if (tmr_done)
        begin
          s_d    = swtc_pkg::SWTC_SLEEP;
          ld     = 1'b1;
          ld_val = sleep_val;
          ind_d  = 1'b0;
          if (sync_m)
          begin
            mss_d  = (mss_q == 16'hffff) ? mss_q : mss_q + 16'h0001;
            sq_inc = !cyc_q && !coord;
          end
        end
      swtc_pkg::SWTC_SLEEP:
        if (tmr_done)
        begin
          ld = 1'b1;
          if (sync_m)
          begin
            // cycle count ignored here
            s_d        = swtc_pkg::SWTC_WAKE;
            ld_val     = eff_wake;
            ind_d      = 1'b1;
            cyc_d      = 1'b0;
            wake_start = 1'b1;
            tx_d       = coord;
            mss_d      = (mss_q == 16'hffff) ? mss_q : mss_q + 16'h0001;
          end
          else if (wcnt_q + 16'h0001 >= cnt_q)
          begin
            s_d    = swtc_pkg::SWTC_WAKE;
            ld_val = entry_val;
            ind_d  = 1'b1;
            wcnt_d = 16'h0000;
          end
          else
          begin
            s_d    = swtc_pkg::SWTC_CHECK;
            ld_val = CHECK_MS;
            wcnt_d = wcnt_q + 16'h0001;
          end
        end
      swtc_pkg::SWTC_CHECK:
        if (data_seen)
        begin
          s_d    = swtc_pkg::SWTC_WAKE;
          ld     = 1'b1;
          ld_val = st_q;
          ind_d  = 1'b1;
          wcnt_d = 16'h0000;
        end
        else if (tmr_done)
        begin
          s_d    = swtc_pkg::SWTC_SLEEP;
          ld     = 1'b1;
          ld_val = sleep_val;
        end
      default:
        s_d = swtc_pkg::SWTC_IDLE;
    endcase
    if (!(async_m || sync_m))
    begin
      s_d    = swtc_pkg::SWTC_IDLE;
      ind_d  = 1'b1;
      wcnt_d = 16'h0000;
    end
    if (sync_rx && sync_m && !opt_q[`SWTC_OPT_PREF])
    begin
      syn_d  = 1'b1;
      ever_d = 1'b1;
      cyc_d  = 1'b1;
      nsp_d  = sync_sp;
      nst_d  = sync_st;
      mss_d  = 16'h0000;
    end
    if (!sync_m)
      syn_d = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q        <= swtc_pkg::SWTC_IDLE;
      wcnt_q     <= 16'h0000;
      mss_q      <= 16'h0000;
      nsp_q      <= 24'h000000;
      nst_q      <= 24'h000000;
      syn_q      <= 1'b0;
      ever_q     <= 1'b0;
      cyc_q      <= 1'b0;
      host_ind_q <= 1'b1;
      sync_tx_q  <= 1'b0;
    end
    else
    begin
      s_q        <= s_d;
      wcnt_q     <= wcnt_d;
      mss_q      <= mss_d;
      nsp_q      <= nsp_d;
      nst_q      <= nst_d;
      syn_q      <= syn_d;
      ever_q     <= ever_d;
      cyc_q      <= cyc_d;
      host_ind_q <= ind_d;
      sync_tx_q  <= tx_d;
    end
  end

  // ==========================================
  // timers
  swtc_tick_div #(.CYC(MS_CYCLES)) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick_q  (ms_tick)
  );
  swtc_ms_timer #(.W(24)) u_seq_tmr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (ms_tick),
    .load     (ld),
    .load_val (ld_val),
    // leaving the cyclic modes drops any half-run period
    .stop     (!(async_m || sync_m)),
    .busy     (),
    .done_q   (tmr_done)
  );
  // host delay restarts on each indicator rise, killed by host traffic
  swtc_ms_timer #(.W(16)) u_wh_tmr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (ms_tick),
    .load     (ind_d && !host_ind_q && wh_q != 16'h0000),
    .load_val (wh_q),
    .stop     (uart_rx_char),
    .busy     (wh_busy),
    .done_q   (wh_done)
  );
  assign host_hold = wh_busy && !wh_done;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_opt_bad;
    wr && cmd_sel == `SWTC_SEL_OPT && cmd_wdata[0] && cmd_wdata[1];
  endsequence
  property p_opt_refuse;
    s_opt_bad |=> rsp_err_q && opt_q == $past(opt_q);
  endproperty
  a_opt_refuse : assert property (p_opt_refuse) else $error("bad option accepted");
  property p_opt_legal;
    opt_q <= 16'h013e && !(opt_q[0] && opt_q[1]);
  endproperty
  a_opt_legal : assert property (p_opt_legal) else $error("option word illegal");
  sequence s_short_wake;
    async_m && s_q == swtc_pkg::SWTC_SLEEP && tmr_done && wcnt_q + 16'h0001 < cnt_q;
  endsequence
  property p_nth;
    s_short_wake |=> s_q == swtc_pkg::SWTC_CHECK && !host_ind_q;
  endproperty
  a_nth : assert property (p_nth) else $error("indicator on a non-Nth wake");
  property p_check_data;
    async_m && s_q == swtc_pkg::SWTC_CHECK && data_seen |=>
      s_q == swtc_pkg::SWTC_WAKE && host_ind_q && wcnt_q == 16'h0000;
  endproperty
  a_check_data : assert property (p_check_data) else $error("data not woken");
  property p_wh_stop;
    uart_rx_char && !(ind_d && !host_ind_q) |=> !host_hold;
  endproperty
  a_wh_stop : assert property (p_wh_stop) else $error("host delay not stopped");
  property p_sq_sat;
    sq_q == 16'hffff && !(wr && cmd_sel == `SWTC_SEL_SQ) |=> sq_q == 16'hffff;
  endproperty
  a_sq_sat : assert property (p_sq_sat) else $error("missed sync wrapped");
  property p_sync_wake;
    sync_m && s_q == swtc_pkg::SWTC_SLEEP && tmr_done |->
      ld_val >= min_wake && ld_val <= 24'h36ee80 ##1 host_ind_q;
  endproperty
  a_sync_wake : assert property (p_sync_wake) else $error("sync wake time bad");
  property p_os;
    cmd_valid && cmd_sel == `SWTC_SEL_OS && !syn_q |=> rsp_data_q == $past(sp_q);
  endproperty
  a_os : assert property (p_os) else $error("os readout wrong");
endmodule
`default_nettype wire

// File: tb/swtc_peer_model.sv
// partner model: host serial side and network peer nodes
`timescale 1ns/100ps
`default_nettype none
module swtc_peer_model (
  input  wire logic   clk,
  output logic        uart_rx_char,
  output logic        rf_rx_pkt,
  output logic        sync_rx,
  output logic [23:0] sync_sp,
  output logic [23:0] sync_st,
  output logic        nominate_req
);
  initial
  begin
    uart_rx_char = 1'b0;
    rf_rx_pkt    = 1'b0;
    sync_rx      = 1'b0;
    sync_sp      = 24'h000000;
    sync_st      = 24'h000000;
    nominate_req = 1'b0;
  end
  // ==========================================
  // event pulses: 0 host character, 1 radio data, 2 nomination
  task automatic pulse(input int k);
    @(posedge clk);
    uart_rx_char <= (k == 0);
    rf_rx_pkt    <= (k == 1);
    nominate_req <= (k == 2);
    @(posedge clk);
    uart_rx_char <= 1'b0;
    rf_rx_pkt    <= 1'b0;
    nominate_req <= 1'b0;
  endtask
  // ==========================================
  // sync message; fields scrambled afterwards so nothing leans on stale values
  task automatic send_sync(input logic [23:0] sp, input logic [23:0] st);
    @(posedge clk);
    sync_rx <= 1'b1;
    sync_sp <= sp;
    sync_st <= st;
    @(posedge clk);
    sync_rx <= 1'b0;
    sync_sp <= ~sp;
    sync_st <= ~st;
  endtask
endmodule
`default_nettype wire

// File: tb/sleep_wake_timing_controller_test.sv
// self-checking bench of the sleep and wake timing controller
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_timing_controller_test;
  logic        clk;
  logic        sys_rst;
  logic        cmd_valid;
  logic        cmd_write;
  logic [3:0]  cmd_sel;
  logic [23:0] cmd_wdata;
  logic        uart_rx_char;
  logic        rf_rx_pkt;
  logic        sync_rx;
  logic [23:0] sync_sp;
  logic [23:0] sync_st;
  logic        nominate_req;
  logic        rsp_valid_q;
  logic [23:0] rsp_data_q;
  logic        rsp_err_q;
  logic        host_ind_q;
  logic        host_hold;
  logic        sync_tx_q;
  logic        coord;
  logic [23:0] v;
  logic        er;
  int          n;
  int          num_errors;
  int          checks_done;
  // sel, write value, expected refusal
  logic [28:0] tbl [20] = '{
    {4'h0, 24'h00013f, 1'b1}, {4'h0, 24'h000003, 1'b1}, {4'h0, 24'h00013e, 1'b0},
    {4'h1, 24'h000000, 1'b1}, {4'h1, 24'h010000, 1'b1}, {4'h1, 24'h00ffff, 1'b0},
    {4'h2, 24'h000000, 1'b1}, {4'h2, 24'h15f901, 1'b1}, {4'h2, 24'h15f900, 1'b0},
    {4'h3, 24'h000000, 1'b1}, {4'h3, 24'h36ee81, 1'b1}, {4'h3, 24'h36ee80, 1'b0},
    {4'h4, 24'h010000, 1'b1}, {4'h4, 24'h00ffff, 1'b0}, {4'h9, 24'h000001, 1'b1},
    {4'h9, 24'h000000, 1'b0}, {4'h5, 24'h000000, 1'b1}, {4'h6, 24'h000001, 1'b1},
    {4'ha, 24'h000006, 1'b1}, {4'ha, 24'h000000, 1'b0}};
  logic [3:0]  dsel [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hf};
  logic [23:0] dval [8] = '{24'h000002, 24'h000001, 24'h00012c, 24'h000d08,
                            24'h000000, 24'h000000, 24'h000000, 24'h000000};

  swtc_core #(.MS_CYCLES(4), .CHECK_MS(24'h000004)) dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .uart_rx_char(uart_rx_char),
    .rf_rx_pkt(rf_rx_pkt), .sync_rx(sync_rx), .sync_sp(sync_sp), .sync_st(sync_st),
    .nominate_req(nominate_req), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .rsp_err_q(rsp_err_q), .host_ind_q(host_ind_q), .host_hold(host_hold),
    .sync_tx_q(sync_tx_q), .coord(coord));
  swtc_peer_model peer (
    .clk(clk), .uart_rx_char(uart_rx_char), .rf_rx_pkt(rf_rx_pkt), .sync_rx(sync_rx),
    .sync_sp(sync_sp), .sync_st(sync_st), .nominate_req(nominate_req));

  always #5 clk = ~clk;
  // ==========================================
  // helpers
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      $display("BAD %0t %s", $time, m);
      num_errors++;
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] s, input logic [23:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_sel   <= s;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk(rsp_valid_q === 1'b1, "no response");
    v  = rsp_data_q;
    er = rsp_err_q;
  endtask
  task automatic wr(input logic [3:0] s, input logic [23:0] d, input logic e);
    acc(1'b1, s, d);
    chk(er === e, "write refusal flag");
  endtask
  task automatic rd(input logic [3:0] s, input logic [23:0] e);
    acc(1'b0, s, 24'h000000);
    chk(v === e, "read value");
  endtask
  // cycles until the host indicator reaches level l
  task automatic wait_ind(input logic l, input int lim);
    n = 0;
    while (host_ind_q !== l && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // watchdog: the whole run needs about 2000 cycles
  initial
  begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  // ==========================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 4'h0;
    cmd_wdata = 24'h000000;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(dsel[i], dval[i]);
    $display("test defaults done");
    for (int i = 0; i < 20; i++) wr(tbl[i][28:25], tbl[i][24:1], tbl[i][0]);
    rd(4'h0, 24'h00013e);
    $display("test ranges done");
    // async: sleep 10 ms = 40 clocks, wake time 10 ms = 40 clocks
    wr(4'h0, 24'h000002, 1'b0);
    wr(4'h1, 24'h000001, 1'b0);
    wr(4'h2, 24'h000001, 1'b0);
    wr(4'h3, 24'h00000a, 1'b0);
    wr(4'h4, 24'h000000, 1'b0);
    wr(4'ha, 24'h000004, 1'b0);
    wait_ind(1'b0, 200);
    wait_ind(1'b1, 200);
    chk(n >= 36 && n <= 52, "sleep length");
    wait_ind(1'b0, 200);
    chk(n >= 10 && n <= 20, "brief wake length");
    wr(4'h0, 24'h000102, 1'b0);
    wait_ind(1'b1, 200);
    wait_ind(1'b0, 200);
    chk(n >= 34 && n <= 46, "full wake length");
    wr(4'h0, 24'h000002, 1'b0);
    wait_ind(1'b1, 200);
    fork
      peer.pulse(1);
      wait_ind(1'b0, 200);
    join
    chk(n >= 36 && n <= 50, "data extends wake");
    wr(4'h1, 24'h000002, 1'b0);
    wait_ind(1'b1, 300);
    wait_ind(1'b0, 200);
    wait_ind(1'b1, 300);
    chk(n >= 85 && n <= 110, "every second wake asserts");
    wait_ind(1'b0, 200);
    fork
      begin
        repeat (43) @(posedge clk);
        peer.pulse(1);
      end
      wait_ind(1'b1, 300);
    join
    chk(n >= 42 && n <= 52, "data during check wakes fully");
    $display("test async done");
    wr(4'h1, 24'h000001, 1'b0);
    wr(4'h4, 24'h000003, 1'b0);
    wait_ind(1'b0, 200);
    wait_ind(1'b1, 200);
    @(posedge clk);
    #1;
    chk(host_hold === 1'b1, "host delay running");
    peer.pulse(0);
    #1;
    chk(host_hold === 1'b0, "host char stops delay");
    wr(4'h4, 24'h000000, 1'b0);
    $display("test host delay done");
    // sync: configured sleep 20 ms, wake 5 ms
    wr(4'ha, 24'h000000, 1'b0);
    wr(4'h2, 24'h000002, 1'b0);
    wr(4'h3, 24'h000005, 1'b0);
    wr(4'h0, 24'h000000, 1'b0);
    wr(4'ha, 24'h000008, 1'b0);
    rd(4'h6, 24'h000002);
    rd(4'h7, 24'h000005);
    acc(1'b0, 4'h5, 24'h000000);
    chk((v & 24'h000066) === 24'h000042, "unsynced status");
    chk(coord === 1'b1, "unsynced node leads");
    peer.send_sync(24'h000003, 24'h000009);
    rd(4'h6, 24'h000003);
    rd(4'h7, 24'h000009);
    acc(1'b0, 4'h5, 24'h000000);
    chk((v & 24'h000066) === 24'h000004, "synced status");
    chk(coord === 1'b0, "synced node follows");
    repeat (700) @(posedge clk);
    acc(1'b0, 4'h8, 24'h000000);
    chk(v > 24'h000000 && v < 24'h000020, "cycles since sync");
    acc(1'b0, 4'h9, 24'h000000);
    chk(v > 24'h000000 && v < 24'h000010, "missed syncs counted");
    wr(4'h9, 24'h000000, 1'b0);
    rd(4'h9, 24'h000000);
    peer.pulse(2);
    acc(1'b0, 4'h5, 24'h000000);
    chk(v[5] === 1'b1, "nomination flag");
    wr(4'h0, 24'h000001, 1'b0);
    chk(coord === 1'b1, "forced coordinator");
    n = 0;
    while (sync_tx_q !== 1'b1 && n < 800)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 800, "coordinator sends sync");
    $display("test sync done");
    results();
  end
endmodule
`default_nettype wire
